// [hdl/ssw_pkg.sv]
// Purpose: Shared constants for the supply supervisor (reset and warning).
// Assumes: 32-bit AHB-Lite register bus, 20 MHz clock.
// Notes:   Offsets are byte addresses inside the slave window.
package ssw_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int unsigned     ADDR_W          = 8;
  localparam logic [7:0]      CTRL_OFS        = 8'h00;
  localparam logic [7:0]      STATUS_OFS      = 8'h04;

  localparam int unsigned     CTRL_EN_BIT     = 0;
  localparam logic            CTRL_EN_RST     = 1'b0;

  localparam int unsigned     STAT_WARN_BIT   = 0;
  localparam int unsigned     STAT_BROWN_BIT  = 1;
  localparam int unsigned     STAT_PIN_BIT    = 2;
  localparam int unsigned     STAT_LVL_LSB    = 3;
  localparam int unsigned     STAT_BOREN_BIT  = 5;
  localparam int unsigned     STAT_LONG_BIT   = 6;

  // ----------------------------------------------------------------------
  // Option-byte settings and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0]      LVL_LOW         = 2'h0;
  localparam logic [1:0]      LVL_MED         = 2'h1;
  localparam logic [1:0]      LVL_HIGH        = 2'h2;
  localparam logic [1:0]      LVL_RST         = LVL_LOW;
  localparam logic            SLR_EN_RST      = 1'b1;
  localparam logic            LONG_DLY_RST    = 1'b0;
  localparam logic            WARN_LVL_RST    = 1'b1;
  localparam logic            SUP_OK_RST      = 1'b0;
  localparam logic            BROWN_FLAG_RST  = 1'b0;

  // Warning comparator sits this far above the selected reset level
  localparam int unsigned     WARN_ABOVE_MV   = 200;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned     CNT_W           = 13;
  localparam logic [12:0]     DLY_SHORT_CYC   = 13'h0100;
  localparam logic [12:0]     DLY_LONG_CYC    = 13'h1000;
  localparam int unsigned     SYNC_W          = 13;

  // ----------------------------------------------------------------------
  // Reset sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_BROWN = 3'b001,
    SEQ_DELAY = 3'b010,
    SEQ_RUN   = 3'b100
  } ssw_state_t;

endpackage

// [hdl/ssw_sync.sv]
// Purpose: Two-flop synchroniser for asynchronous comparator and pin levels.
// Assumes: Inputs are slow levels, no bus coherency needed between bits.
// Notes:   First stage is read by the second stage only.
module ssw_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         CLK_I,
  input  wire logic         SYS_RST_I,
  // Levels
  input  wire logic [W-1:0] ASYNC_I,
  output      logic [W-1:0] SYNC_O
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  always_comb begin
    next_meta = ASYNC_I;
    next_sync = meta;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      meta   <= '0;
      SYNC_O <= '0;
    end else begin
      meta   <= next_meta;
      SYNC_O <= next_sync;
    end
  end

endmodule

// [hdl/ssw_top.sv]
// Purpose: Brownout reset with hysteresis, early supply warning, AHB-Lite regs.
// Assumes: Comparator outputs are asynchronous; option bits are static straps.
// Notes:   Brownout flag survives the internal reset; SYS_RST_I or a write of 1 to STATUS bit 1 clears it.

// Function
// - Internal reset held while supply below threshold
// - Hardware sets brownout flag on brownout
// - Rising and falling reset thresholds give hysteresis
// - Option byte picks low, medium, high level
// - Drive external reset pin low during brownout
// - Option byte can disable brownout reset entirely
// - Warning level follows selected reset level choice
// - Warning comparison also uses hysteresis
// - Warning level is read-only real-time status
// - Interrupt on every warning level toggle
// - No rising warning interrupt within reset delay
// - Enable while below gives an interrupt
// - Enable after threshold passed gives one interrupt
module ssw_top (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // Comparators, one bit per level (low, medium, high)
  input  wire logic [2:0]  SUP_ABOVE_RISE_I,
  input  wire logic [2:0]  SUP_ABOVE_FALL_I,
  input  wire logic [2:0]  WARN_ABOVE_RISE_I,
  input  wire logic [2:0]  WARN_ABOVE_FALL_I,
  // Option byte
  input  wire logic [1:0]  OPT_LEVEL_I,
  input  wire logic        OPT_SLR_EN_I,
  input  wire logic        OPT_LONG_DLY_I,
  // External reset pin, open drain
  input  wire logic        EXT_RST_N_I,
  output      logic        EXT_RST_N_O,
  output      logic        EXT_RST_OE_N_O,
  // Internal reset and warning event
  output      logic        INT_RST_O,
  output      logic        WARN_IRQ_O,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output      logic [31:0] HRDATA_O,
  output      logic        HREADYOUT_O,
  output      logic        HRESP_O
);

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  logic [12:0] sync_in;
  logic [12:0] sync_out;
  logic [2:0]  s_sup_rise;
  logic [2:0]  s_sup_fall;
  logic [2:0]  s_warn_rise;
  logic [2:0]  s_warn_fall;
  logic        s_pin;

  assign sync_in = {EXT_RST_N_I, WARN_ABOVE_FALL_I, WARN_ABOVE_RISE_I,
                    SUP_ABOVE_FALL_I, SUP_ABOVE_RISE_I};

  ssw_sync #(
    .W (ssw_pkg::SYNC_W)
  ) u_sync (
    .CLK_I     (CLK_I),
    .SYS_RST_I (SYS_RST_I),
    .ASYNC_I   (sync_in),
    .SYNC_O    (sync_out)
  );

  assign s_sup_rise  = sync_out[2:0];
  assign s_sup_fall  = sync_out[5:3];
  assign s_warn_rise = sync_out[8:6];
  assign s_warn_fall = sync_out[11:9];
  assign s_pin       = sync_out[12];

  // Picks the comparator of the selected level; code 3 falls back to high
  function automatic logic pick_lvl(input logic [2:0] v, input logic [1:0] lvl);
    case (lvl)
      ssw_pkg::LVL_LOW: pick_lvl = v[0];
      ssw_pkg::LVL_MED: pick_lvl = v[1];
      default:          pick_lvl = v[2];
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ssw_pkg::ssw_state_t state;
  ssw_pkg::ssw_state_t next_state;
  logic [12:0] cnt;
  logic [12:0] next_cnt;
  logic        cfg_loaded;
  logic        next_cfg_loaded;
  logic [1:0]  cfg_lvl;
  logic [1:0]  next_cfg_lvl;
  logic        cfg_slr_en;
  logic        next_cfg_slr_en;
  logic        cfg_long;
  logic        next_cfg_long;
  logic        sup_ok;
  logic        next_sup_ok;
  logic        warn_lvl;
  logic        next_warn_lvl;
  logic        warn_prev;
  logic        next_warn_prev;
  logic        warn_en;
  logic        next_warn_en;
  logic        en_prev;
  logic        next_en_prev;
  logic        brown_flag;
  logic        next_brown_flag;
  logic        ext_oe_n;
  logic        next_ext_oe_n;
  logic        irq;
  logic        next_irq;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [7:0]  wr_addr;
  logic [7:0]  next_wr_addr;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  logic        slr_active;
  logic        int_rst;
  logic        addr_ok;
  logic        wr_ctrl;
  logic        clr_brown;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;

  // Strap read directly until latched, so the cfg_slr_en reset value never decides the first cycle
  assign slr_active = (cfg_loaded ? cfg_slr_en : OPT_SLR_EN_I) & ~sup_ok;
  assign int_rst    = (state != ssw_pkg::SEQ_RUN);
  assign addr_ok    = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign wr_ctrl    = wr_pend & (wr_addr == ssw_pkg::CTRL_OFS);
  assign clr_brown  = wr_pend & (wr_addr == ssw_pkg::STATUS_OFS)
                      & HWDATA_I[ssw_pkg::STAT_BROWN_BIT];

  always_comb begin
    status_word = '0;
    status_word[ssw_pkg::STAT_WARN_BIT]  = warn_lvl;
    status_word[ssw_pkg::STAT_BROWN_BIT] = brown_flag;
    status_word[ssw_pkg::STAT_PIN_BIT]   = s_pin;
    status_word[ssw_pkg::STAT_LVL_LSB +: 2] = cfg_lvl;
    status_word[ssw_pkg::STAT_BOREN_BIT] = cfg_slr_en;
    status_word[ssw_pkg::STAT_LONG_BIT]  = cfg_long;
    ctrl_word = '0;
    ctrl_word[ssw_pkg::CTRL_EN_BIT] = warn_en;
  end

  // ----------------------------------------------------------------------
  // Next-value logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_cfg_loaded = 1'b1;
    next_cfg_lvl    = cfg_lvl;
    next_cfg_slr_en = cfg_slr_en;
    next_cfg_long   = cfg_long;
    // Straps caught once after reset release, never while running
    if (!cfg_loaded) begin
      next_cfg_lvl    = OPT_LEVEL_I;
      next_cfg_slr_en = OPT_SLR_EN_I;
      next_cfg_long   = OPT_LONG_DLY_I;
    end

    // Reset threshold hysteresis: up on rising, down below falling
    next_sup_ok = sup_ok;
    if (pick_lvl(s_sup_rise, cfg_lvl)) begin
      next_sup_ok = 1'b1;
    end else if (!pick_lvl(s_sup_fall, cfg_lvl)) begin
      next_sup_ok = 1'b0;
    end

    // Warning comparators are the set tied to the same level choice
    next_warn_lvl = warn_lvl;
    if (pick_lvl(s_warn_rise, cfg_lvl)) begin
      next_warn_lvl = 1'b0;
    end else if (!pick_lvl(s_warn_fall, cfg_lvl)) begin
      next_warn_lvl = 1'b1;
    end
    next_warn_prev = warn_lvl;

    next_state = state;
    next_cnt   = cnt;
    case (state)
      ssw_pkg::SEQ_BROWN: begin
        if (!slr_active) begin
          next_state = ssw_pkg::SEQ_DELAY;
          next_cnt   = ((cfg_loaded ? cfg_long : OPT_LONG_DLY_I) ?
                        ssw_pkg::DLY_LONG_CYC : ssw_pkg::DLY_SHORT_CYC) - 13'h0001;
        end
      end
      ssw_pkg::SEQ_DELAY: begin
        if (slr_active) begin
          next_state = ssw_pkg::SEQ_BROWN;
        end else if (cnt == 13'h0000) begin
          next_state = ssw_pkg::SEQ_RUN;
        end else begin
          next_cnt = cnt - 13'h0001;
        end
      end
      ssw_pkg::SEQ_RUN: begin
        if (slr_active) begin
          next_state = ssw_pkg::SEQ_BROWN;
        end
      end
      default: begin
        next_state = ssw_pkg::SEQ_BROWN;
      end
    endcase

    // Set beats a clear that lands in the same cycle
    next_brown_flag = brown_flag;
    if (clr_brown) begin
      next_brown_flag = 1'b0;
    end
    if (slr_active) begin
      next_brown_flag = 1'b1;
    end

    next_ext_oe_n = ~slr_active;

    next_warn_en = warn_en;
    if (wr_ctrl) begin
      next_warn_en = HWDATA_I[ssw_pkg::CTRL_EN_BIT];
    end
    if (int_rst) begin
      next_warn_en = ssw_pkg::CTRL_EN_RST;
    end
    next_en_prev = warn_en;

    // Edges seen during the internal reset are absorbed by warn_prev
    next_irq = ~int_rst & warn_en & (warn_lvl != warn_prev);
    if (~int_rst & warn_en & ~en_prev & warn_lvl) begin
      next_irq = 1'b1;
    end
    // Enable while above: no event until the next crossing

    next_wr_pend = addr_ok & HWRITE_I;
    next_wr_addr = wr_addr;
    next_rdata   = rdata;
    if (addr_ok) begin
      next_wr_addr = HADDR_I[7:0];
      if (!HWRITE_I) begin
        case (HADDR_I[7:0])
          ssw_pkg::CTRL_OFS:   next_rdata = ctrl_word;
          ssw_pkg::STATUS_OFS: next_rdata = status_word;
          default:             next_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state      <= ssw_pkg::SEQ_BROWN;
      cnt        <= 13'h0000;
      cfg_loaded <= 1'b0;
      cfg_lvl    <= ssw_pkg::LVL_RST;
      cfg_slr_en <= ssw_pkg::SLR_EN_RST;
      cfg_long   <= ssw_pkg::LONG_DLY_RST;
      sup_ok     <= ssw_pkg::SUP_OK_RST;
      warn_lvl   <= ssw_pkg::WARN_LVL_RST;
      warn_prev  <= ssw_pkg::WARN_LVL_RST;
      warn_en    <= ssw_pkg::CTRL_EN_RST;
      en_prev    <= ssw_pkg::CTRL_EN_RST;
      brown_flag <= ssw_pkg::BROWN_FLAG_RST;
      ext_oe_n   <= 1'b1;
      irq        <= 1'b0;
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      rdata      <= 32'h0000_0000;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      cfg_loaded <= next_cfg_loaded;
      cfg_lvl    <= next_cfg_lvl;
      cfg_slr_en <= next_cfg_slr_en;
      cfg_long   <= next_cfg_long;
      sup_ok     <= next_sup_ok;
      warn_lvl   <= next_warn_lvl;
      warn_prev  <= next_warn_prev;
      warn_en    <= next_warn_en;
      en_prev    <= next_en_prev;
      brown_flag <= next_brown_flag;
      ext_oe_n   <= next_ext_oe_n;
      irq        <= next_irq;
      wr_pend    <= next_wr_pend;
      wr_addr    <= next_wr_addr;
      rdata      <= next_rdata;
    end
  end

  assign INT_RST_O      = int_rst;
  assign EXT_RST_N_O    = 1'b0;
  assign EXT_RST_OE_N_O = ext_oe_n;
  assign WARN_IRQ_O     = irq;
  assign HRDATA_O       = rdata;
  assign HREADYOUT_O    = 1'b1;
  assign HRESP_O        = 1'b0;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_slr_holds_reset: assert property (slr_active |-> ##1 INT_RST_O)
    else $error("internal reset released during brownout");
  chk_flag_sets: assert property (slr_active |=> brown_flag)
    else $error("brownout flag not set");
  chk_hyst_keeps: assert property (
    (pick_lvl(s_sup_fall, cfg_lvl) && !pick_lvl(s_sup_rise, cfg_lvl))
    |=> (sup_ok == $past(sup_ok)))
    else $error("reset hysteresis band changed state");
  chk_level_stable: assert property (cfg_loaded |=> $stable(cfg_lvl))
    else $error("level option changed while running");
  chk_pin_driven: assert property (slr_active |=> !EXT_RST_OE_N_O)
    else $error("external reset pin not driven in brownout");
  chk_slr_disabled: assert property (
    (!cfg_slr_en && cfg_loaded && state == ssw_pkg::SEQ_RUN) |=> state == ssw_pkg::SEQ_RUN)
    else $error("brownout reset while disabled");
  chk_warn_hyst: assert property (
    (pick_lvl(s_warn_fall, cfg_lvl) && !pick_lvl(s_warn_rise, cfg_lvl)) |=> $stable(warn_lvl))
    else $error("warning hysteresis band changed state");
  chk_toggle_irq: assert property (
    (warn_en && !int_rst && warn_lvl != warn_prev) |=> WARN_IRQ_O)
    else $error("missing warning interrupt on toggle");
  chk_quiet_in_reset: assert property (int_rst |=> !WARN_IRQ_O)
    else $error("warning interrupt during reset delay");
  chk_delay_done: assert property (
    $rose(state == ssw_pkg::SEQ_RUN) |-> ($past(cnt) == 13'h0000))
    else $error("run entered before delay expired");
  chk_enable_irq: assert property (
    ($rose(warn_en) && warn_lvl && !int_rst) |=> WARN_IRQ_O)
    else $error("no interrupt on enable below threshold");
  chk_flag_sticky: assert property ((brown_flag && !clr_brown) |=> brown_flag)
    else $error("brownout flag lost without clear");

  cov_brownout: cover property (state == ssw_pkg::SEQ_RUN ##1 state == ssw_pkg::SEQ_BROWN);
  cov_warn_irq: cover property (WARN_IRQ_O ##[1:20] WARN_IRQ_O);
  cov_flag_clear: cover property (brown_flag ##1 !brown_flag);

endmodule

// [tb/ssw_rst_peer.sv]
// Purpose: Peer devices on the shared external reset wire.
// Assumes: Open-drain drivers only; a pull-up sets the released level.
// Notes:   A peer stays in reset while the wire is low.
module ssw_rst_peer (
  // Clock
  input  wire logic clk_i,
  // Block side of the pin
  input  wire logic oe_n_i,
  input  wire logic data_i,
  // Peer pulls the wire itself
  input  wire logic pull_i,
  // Wire level and peer state
  output      logic wire_o,
  output      logic held_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released wire shows the pull-up, never a stale value
  assign wire_o = ((oe_n_i === 1'b0) ? data_i : 1'b1) & ~pull_i;
  always_ff @(posedge clk_i) begin
    held_o <= ~wire_o;
  end
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the supply supervisor.
// Assumes: Comparator levels are driven directly; slave is zero wait.
// Notes:   Interrupt pulses are counted, so a held level shows as extra.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        clk, rst, slr_en, long_dly, pull, hsel, hwrite;
  logic [2:0]  sup_r, sup_f, warn_r, warn_f, hsize, sel;
  logic [1:0]  lvl, htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        hready, hresp, ext_n, ext_o, oe_n, int_rst, irq, held;
  int          bad_count, samples_checked, irq_total, n, base, lv;

  ssw_top i_dut (.CLK_I(clk), .SYS_RST_I(rst), .SUP_ABOVE_RISE_I(sup_r),
    .SUP_ABOVE_FALL_I(sup_f), .WARN_ABOVE_RISE_I(warn_r), .WARN_ABOVE_FALL_I(warn_f),
    .OPT_LEVEL_I(lvl), .OPT_SLR_EN_I(slr_en), .OPT_LONG_DLY_I(long_dly),
    .EXT_RST_N_I(ext_n), .EXT_RST_N_O(ext_o), .EXT_RST_OE_N_O(oe_n),
    .INT_RST_O(int_rst), .WARN_IRQ_O(irq), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp));
  ssw_rst_peer i_peer (.clk_i(clk), .oe_n_i(oe_n), .data_i(ext_o), .pull_i(pull),
    .wire_o(ext_n), .held_o(held));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  // Only the watchdog ends a wait for the slave
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) begin
      @(posedge clk);
    end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) begin
      @(posedge clk);
    end
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask
  task automatic rst_pulse;
    rst <= 1'b1;
    cyc(6);
    rst <= 1'b0;
  endtask
  task automatic wait_rel(output int c);
    c = 0;
    while (int_rst !== 1'b0 && c < 6000) begin
      @(posedge clk);
      c++;
    end
  endtask
  // Pin bit assumed released
  function automatic logic [31:0] stat_exp(input logic [1:0] l, input logic f, input logic w);
    stat_exp = {25'h0, long_dly, slr_en, l, 1'b1, f, w};
  endfunction
  task automatic close_out;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Clock, pulse counter, watchdog
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irq === 1'b1) irq_total++;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    close_out();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1; sup_r = 3'h7; sup_f = 3'h7; warn_r = 3'h7; warn_f = 3'h7;
    lvl = 2'h0; slr_en = 1'b1; long_dly = 1'b0; pull = 1'b0; hsel = 1'b1;
    hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    bad_count = 0; samples_checked = 0; irq_total = 0;
    for (lv = 0; lv < 3; lv++) begin
      sel = 3'h1 << lv;
      lvl <= lv[1:0];
      rst_pulse();
      wait_rel(n);
      chk(n >= 256 && n <= 270, 32'h1, "boot delay");
      chk(irq_total, 32'h0, "irq at boot");
      // Synchronisers start low, so each reset release reports a brownout
      rdc(8'h04, stat_exp(lv[1:0], 1'b1, 1'b0), "status");
      bus(1'b1, 8'h04, 32'h2);
      rdc(8'h04, stat_exp(lv[1:0], 1'b0, 1'b0), "boot clear");
      sup_r <= sel;
      sup_f <= sel;
      cyc(8);
      chk(int_rst, 32'h0, "other level");
      sup_r <= 3'h0;
      cyc(8);
      chk(int_rst, 32'h0, "falling hyst");
      sup_f <= 3'h0;
      cyc(8);
      chk(int_rst, 32'h1, "no brownout");
      chk(held, 32'h1, "peer free");
      sup_f <= 3'h7;
      cyc(8);
      chk(int_rst, 32'h1, "rising hyst");
      sup_r <= 3'h7;
      wait_rel(n);
      chk(n >= 256 && n <= 270, 32'h1, "release");
      chk(oe_n, 32'h1, "pin held");
      rdc(8'h04, stat_exp(lv[1:0], 1'b1, 1'b0), "flag");
      bus(1'b1, 8'h04, 32'h3);
      rdc(8'h04, stat_exp(lv[1:0], 1'b0, 1'b0), "clear");
    end
    base = irq_total;
    warn_r <= 3'h3;
    warn_f <= 3'h3;
    cyc(8);
    rdc(8'h04, stat_exp(2'h2, 1'b0, 1'b1), "warn lvl");
    chk(irq_total, base, "irq off");
    bus(1'b1, 8'h00, 32'h1);
    cyc(4);
    chk(irq_total, base + 1, "enable irq");
    warn_r <= 3'h0;
    warn_f <= 3'h0;
    cyc(8);
    chk(irq_total, base + 1, "other warn");
    warn_f <= 3'h4;
    cyc(8);
    chk(irq_total, base + 1, "warn hyst up");
    warn_r <= 3'h4;
    cyc(8);
    chk(irq_total, base + 2, "rise irq");
    warn_r <= 3'h0;
    cyc(8);
    chk(irq_total, base + 2, "warn hyst dn");
    warn_f <= 3'h0;
    cyc(8);
    chk(irq_total, base + 3, "fall irq");
    bus(1'b1, 8'h00, 32'h0);
    warn_r <= 3'h7;
    warn_f <= 3'h7;
    cyc(8);
    bus(1'b1, 8'h00, 32'h1);
    cyc(4);
    rdc(8'h00, 32'h1, "ctrl");
    warn_r <= 3'h0;
    warn_f <= 3'h0;
    cyc(8);
    chk(irq_total, base + 4, "late enable");
    pull <= 1'b1;
    cyc(6);
    rdc(8'h04, stat_exp(2'h2, 1'b0, 1'b1) & ~32'h4, "pin low");
    chk(int_rst, 32'h0, "peer reset");
    pull <= 1'b0;
    rdc(8'h08, 32'h0, "unmapped");
    slr_en <= 1'b0;
    rst_pulse();
    wait_rel(n);
    sup_r <= 3'h0;
    sup_f <= 3'h0;
    cyc(10);
    chk(int_rst, 32'h0, "reset off");
    chk(oe_n, 32'h1, "reset off pin");
    rdc(8'h04, stat_exp(2'h2, 1'b0, 1'b1), "reset off flag");
    sup_r <= 3'h7;
    sup_f <= 3'h7;
    slr_en <= 1'b1;
    long_dly <= 1'b1;
    rst_pulse();
    base = irq_total;
    cyc(100);
    warn_r <= 3'h7;
    warn_f <= 3'h7;
    wait_rel(n);
    chk(n + 100 >= 4096 && n + 100 <= 4110, 32'h1, "long delay");
    chk(irq_total, base, "rise in delay");
    rdc(8'h04, stat_exp(2'h2, 1'b1, 1'b0), "long status");
    close_out();
  end
endmodule
